// ==== include/ctrl_channel_gpio_cfg_defs.vh ====
`ifndef CTRL_CHANNEL_GPIO_CFG_DEFS_VH
`define CTRL_CHANNEL_GPIO_CFG_DEFS_VH

// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define IDX_BRIDGE_CFG      8'h0d
`define IDX_GPIO_FWD        8'h0e
`define IDX_DET_THR         8'h0f
`define IDX_DET_COUNT       8'h10
`define IDX_ERR_SEL         8'h08
`define IDX_IRQ_STATUS      8'h20
`define IDX_IRQ_MASK        8'h21
`define ADDR_BRIDGE_CFG     {`IDX_BRIDGE_CFG, 2'b00}
`define ADDR_GPIO_FWD       {`IDX_GPIO_FWD, 2'b00}
`define ADDR_DET_THR        {`IDX_DET_THR, 2'b00}
`define ADDR_DET_COUNT      {`IDX_DET_COUNT, 2'b00}
`define ADDR_ERR_SEL        {`IDX_ERR_SEL, 2'b00}
`define ADDR_IRQ_STATUS     {`IDX_IRQ_STATUS, 2'b00}
`define ADDR_IRQ_MASK       {`IDX_IRQ_MASK, 2'b00}

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_LOCAL_ACK       7
`define SH_HI               6
`define SH_LO               5
`define RATE_HI             4
`define RATE_LO             2
`define TO_HI               1
`define TO_LO               0
`define BIT_FWD_EN          5
`define BIT_TRIG_IN         4
`define BIT_PIN1_OUT        3
`define BIT_PIN1_IN         2
`define BIT_PIN0_OUT        1
`define BIT_PIN0_IN         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BRIDGE_CFG      8'h36
`define RST_GPIO_FWD_W      8'h6a
`define RST_DET_THR         8'h00
`define RST_DET_COUNT       8'h00
`define RST_ERR_SEL         2'h0
`define RST_IRQ_MASK        2'h0

// ----------------------------------------
// Timeout counts in microseconds, and the clock rate
// ----------------------------------------
`define CLK_MHZ             250
`define TO_US_0             64
`define TO_US_1             256
`define TO_US_2             1024

`endif

// ==== src/ctrl_channel_gpio_cfg_regs.v ====
`timescale 1ns/1ps
`include "ctrl_channel_gpio_cfg_defs.vh"
// Notes on behaviour
// - With local-ack set, slave acknowledges locally when forward channel is down.
// - Two-bit setup/hold select, codes 00..11 give four timings, resets to 01.
// - Three-bit master bit-rate select, eight rates, resets to 101.
// - Two-bit remote timeout select: 64, 256, 1024 us or none; resets 10.
// - Input level is forwarded to the far end only while forward enable is set.
// - Eight-bit read/write detected-error threshold, resets to zero.
// - With error select 00, error flag rises when count exceeds threshold.
// - Detected-error count is an eight-bit read-only register resetting to zero.
module ctrl_channel_gpio_cfg_regs
#(
  parameter TIMEOUT_US_0 = `TO_US_0,
  parameter TIMEOUT_US_1 = `TO_US_1,
  parameter TIMEOUT_US_2 = `TO_US_2
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write address
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Bridge control
  input  wire        fwdChannelUp,
  input  wire        bridgeAckRequest,
  output reg         bridgeLocalAck,
  output reg  [1:0]  bridgeSlaveSetupHoldSel,
  output reg  [2:0]  bridgeMasterRateSel,
  output reg  [1:0]  bridgeSlaveTimeoutSel,
  input  wire        bridgeRemoteWaitStart,
  input  wire        bridgeRemoteDone,
  output reg         bridgeRemoteTimeout,
  // Input forwarding and pins
  input  wire        triggerInputLevel,
  output reg         triggerForwardLevel,
  output reg         triggerForwardValid,
  input  wire        pin0In,
  input  wire        pin1In,
  output reg         pin0Out,
  output reg         pin0Oe_n,
  output reg         pin1Out,
  output reg         pin1Oe_n,
  // Error counting
  input  wire        detectedErrorPulse,
  output reg         errorFlag,
  output reg         irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  bridgeCfg_reg;
  reg         fwdEnable_reg;
  reg  [1:0]  gpioReserved_reg;
  reg         pin1Drive_reg;
  reg         pin0Drive_reg;
  reg  [7:0]  detected_error_threshold_reg;
  reg  [7:0]  detCount_reg;
  reg  [1:0]  error_flag_source_sel_reg;
  reg  [1:0]  irqStatus_reg;
  reg  [1:0]  irqMask_reg;
  reg  [2:0]  trigSync_reg;
  reg  [2:0]  pin0Sync_reg;
  reg  [2:0]  pin1Sync_reg;
  reg         trigLevel_reg;
  reg         pin0Level_reg;
  reg         pin1Level_reg;
  reg         errFlagPrev_reg;
  reg  [17:0] toCount_reg;
  reg         toActive_reg;
  reg  [9:0]  awAddr_reg;
  reg         awHave_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;
  reg         wHave_reg;

  wire        doWrite;
  wire [7:0]  gpioReadByte;
  wire        errNow;
  wire        toLimitHit;
  reg  [17:0] toLimit;
  localparam [7:0] gpioRstVal = `RST_GPIO_FWD_W;
  // Cycles per microsecond count, cut to the counter width
  function [17:0] usToCycles;
    input integer us;
    reg [31:0] prod;
    begin
      prod = us * `CLK_MHZ;
      usToCycles = prod[17:0];
    end
  endfunction
  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data taken in either order; response once both are held
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 10'h000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !awHave_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHave_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        case (awAddr_reg[9:2])
          `IDX_BRIDGE_CFG, `IDX_GPIO_FWD, `IDX_DET_THR, `IDX_DET_COUNT,
          `IDX_ERR_SEL, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigSync_reg  <= 3'h0;
      pin0Sync_reg  <= 3'h0;
      pin1Sync_reg  <= 3'h0;
      trigLevel_reg <= 1'b0;
      pin0Level_reg <= 1'b0;
      pin1Level_reg <= 1'b0;
    end
    else
    begin
      trigSync_reg <= {trigSync_reg[1:0], triggerInputLevel};
      pin0Sync_reg <= {pin0Sync_reg[1:0], pin0In};
      pin1Sync_reg <= {pin1Sync_reg[1:0], pin1In};
      // Change accepted once stages two and three agree
      if (trigSync_reg[2] == trigSync_reg[1])
        trigLevel_reg <= trigSync_reg[2];
      if (pin0Sync_reg[2] == pin0Sync_reg[1])
        pin0Level_reg <= pin0Sync_reg[2];
      if (pin1Sync_reg[2] == pin1Sync_reg[1])
        pin1Level_reg <= pin1Sync_reg[2];
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridgeCfg_reg    <= `RST_BRIDGE_CFG;
      fwdEnable_reg    <= gpioRstVal[`BIT_FWD_EN];
      gpioReserved_reg <= gpioRstVal[7:6];
      pin1Drive_reg    <= gpioRstVal[`BIT_PIN1_OUT];
      pin0Drive_reg    <= gpioRstVal[`BIT_PIN0_OUT];
      detected_error_threshold_reg       <= `RST_DET_THR;
      error_flag_source_sel_reg       <= `RST_ERR_SEL;
      irqMask_reg      <= `RST_IRQ_MASK;
    end
    else if (doWrite && wStrb_reg[0])
    begin
      case (awAddr_reg[9:2])
        `IDX_BRIDGE_CFG: bridgeCfg_reg <= wData_reg[7:0];
        `IDX_GPIO_FWD:
        begin
          gpioReserved_reg <= wData_reg[7:6];
          fwdEnable_reg    <= wData_reg[`BIT_FWD_EN];
          pin1Drive_reg    <= wData_reg[`BIT_PIN1_OUT];
          pin0Drive_reg    <= wData_reg[`BIT_PIN0_OUT];
        end
        `IDX_DET_THR: detected_error_threshold_reg <= wData_reg[7:0];
        `IDX_ERR_SEL: error_flag_source_sel_reg <= wData_reg[1:0];
        `IDX_IRQ_MASK: irqMask_reg <= wData_reg[1:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Error count, error flag, timeout
  // ----------------------------------------
  // Only code 00 compares the detected count; other codes use absent counters
  assign errNow = (error_flag_source_sel_reg == 2'h0) && (detCount_reg > detected_error_threshold_reg);
  always @*
  begin
    case (bridgeCfg_reg[`TO_HI:`TO_LO])
      2'h0: toLimit = usToCycles(TIMEOUT_US_0);
      2'h1: toLimit = usToCycles(TIMEOUT_US_1);
      default: toLimit = usToCycles(TIMEOUT_US_2);
    endcase
  end
  assign toLimitHit = toActive_reg && (toCount_reg >= toLimit - 18'h1);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      detCount_reg    <= `RST_DET_COUNT;
      errFlagPrev_reg <= 1'b0;
      toCount_reg     <= 18'h00000;
      toActive_reg    <= 1'b0;
    end
    else
    begin
      // Saturates so a long error burst never wraps below the threshold
      if (detectedErrorPulse && detCount_reg != 8'hff)
        detCount_reg <= detCount_reg + 8'h01;
      errFlagPrev_reg <= errNow;
      if (bridgeRemoteDone || toLimitHit)
      begin
        toActive_reg <= 1'b0;
        toCount_reg  <= 18'h00000;
      end
      else if (bridgeRemoteWaitStart && bridgeCfg_reg[`TO_HI:`TO_LO] != 2'h3)
      begin
        toActive_reg <= 1'b1;
        toCount_reg  <= 18'h00000;
      end
      else if (toActive_reg)
        toCount_reg <= toCount_reg + 18'h00001;
    end
  end
  // ----------------------------------------
  // Interrupt status: bit0 error rise, bit1 remote timeout
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStatus_reg <= 2'h0;
    else
    begin
      // Set wins over the write-one clear
      irqStatus_reg <= (irqStatus_reg & ~((doWrite && wStrb_reg[0] &&
                        awAddr_reg[9:2] == `IDX_IRQ_STATUS) ? wData_reg[1:0] : 2'h0))
                       | {toLimitHit, errNow && !errFlagPrev_reg};
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridgeLocalAck          <= 1'b0;
      bridgeSlaveSetupHoldSel <= 2'h0;
      bridgeMasterRateSel     <= 3'h0;
      bridgeSlaveTimeoutSel   <= 2'h0;
      bridgeRemoteTimeout     <= 1'b0;
      triggerForwardLevel     <= 1'b0;
      triggerForwardValid     <= 1'b0;
      pin0Out                 <= 1'b0;
      pin1Out                 <= 1'b0;
      pin0Oe_n                <= 1'b1;
      pin1Oe_n                <= 1'b1;
      errorFlag               <= 1'b0;
      irq                     <= 1'b0;
    end
    else
    begin
      bridgeLocalAck <= bridgeCfg_reg[`BIT_LOCAL_ACK] && !fwdChannelUp
                        && bridgeAckRequest;
      bridgeSlaveSetupHoldSel <= bridgeCfg_reg[`SH_HI:`SH_LO];
      bridgeMasterRateSel     <= bridgeCfg_reg[`RATE_HI:`RATE_LO];
      bridgeSlaveTimeoutSel   <= bridgeCfg_reg[`TO_HI:`TO_LO];
      bridgeRemoteTimeout     <= toLimitHit;
      triggerForwardValid     <= fwdEnable_reg;
      triggerForwardLevel     <= fwdEnable_reg && trigLevel_reg;
      // Open-drain style pins: a high is released so the far side can drive low
      pin0Out  <= 1'b0;
      pin1Out  <= 1'b0;
      pin0Oe_n <= pin0Drive_reg;
      pin1Oe_n <= pin1Drive_reg;
      errorFlag <= errNow;
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end
  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign gpioReadByte = {gpioReserved_reg, fwdEnable_reg, trigLevel_reg,
                         pin1Drive_reg, pin1Level_reg, pin0Drive_reg, pin0Level_reg};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[9:2])
          `IDX_BRIDGE_CFG: s_axi_rdata <= {24'h000000, bridgeCfg_reg};
          `IDX_GPIO_FWD:   s_axi_rdata <= {24'h000000, gpioReadByte};
          `IDX_DET_THR:    s_axi_rdata <= {24'h000000, detected_error_threshold_reg};
          `IDX_DET_COUNT:  s_axi_rdata <= {24'h000000, detCount_reg};
          `IDX_ERR_SEL:    s_axi_rdata <= {30'h00000000, error_flag_source_sel_reg};
          `IDX_IRQ_STATUS: s_axi_rdata <= {30'h00000000, irqStatus_reg};
          `IDX_IRQ_MASK:   s_axi_rdata <= {30'h00000000, irqMask_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== testbench/serializer_gpo_model.sv ====
`timescale 1ns/1ps
module serializer_gpo_model
(
  // Link side
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fwdLevel,
  input  wire logic fwdValid,
  // Far output
  output logic      gpoLevel
);
  // Output holds its last level while forwarding is off
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      gpoLevel <= 1'h0;
    else if (fwdValid)
      gpoLevel <= fwdLevel;
endmodule

// ==== testbench/cfg_regs_checker.sv ====
`timescale 1ns/1ps
module cfg_regs_checker
(
  // Clock and bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Bridge and forwarding
  input wire logic        fwdChannelUp,
  input wire logic        bridgeAckRequest,
  input wire logic        bridgeLocalAck,
  input wire logic [1:0]  bridgeSlaveSetupHoldSel,
  input wire logic [2:0]  bridgeMasterRateSel,
  input wire logic [1:0]  bridgeSlaveTimeoutSel,
  input wire logic        triggerForwardLevel,
  input wire logic        triggerForwardValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  local_ack_a: assert property (bridgeLocalAck
    |-> $past(!fwdChannelUp && bridgeAckRequest)) else $error("local ack without cause");
  reset_sel_a: assert property ($rose(rst_n) |=>
    bridgeSlaveSetupHoldSel == 2'h1 && bridgeMasterRateSel == 3'h5
    && bridgeSlaveTimeoutSel == 2'h2) else $error("bad select after reset");
  fwd_gate_a: assert property (triggerForwardLevel |-> triggerForwardValid)
    else $error("level forwarded while disabled");
  rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule
bind ctrl_channel_gpio_cfg_regs cfg_regs_checker chk_u (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .fwdChannelUp(fwdChannelUp),
  .bridgeAckRequest(bridgeAckRequest), .bridgeLocalAck(bridgeLocalAck),
  .bridgeSlaveSetupHoldSel(bridgeSlaveSetupHoldSel),
  .bridgeMasterRateSel(bridgeMasterRateSel), .bridgeSlaveTimeoutSel(bridgeSlaveTimeoutSel),
  .triggerForwardLevel(triggerForwardLevel), .triggerForwardValid(triggerForwardValid));

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "ctrl_channel_gpio_cfg_defs.vh"
module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  reg        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  reg        fwdUp = 1'h1, ackReq = 1'h0, trig = 1'h0, p0In = 1'h0, p1In = 1'h0, errP = 1'h0;
  reg        rws = 1'h0, rdn = 1'h0;
  reg  [9:0] awa = 10'h0, ara = 10'h0;
  reg [31:0] wd = 32'h0, d;
  reg  [1:0] r;
  reg  [2:0] c;
  wire       awr, wr, bv, arr, rv, lAck, rTo, fLvl, fVld, p0O, p0Oe_n, p1O, p1Oe_n, errF, irq;
  wire       gpo;
  wire [1:0] bresp, rresp, shSel, toSel;
  wire [2:0] rateSel;
  wire [31:0] rdata;
  integer    nErrors = 0, checksDone = 0, cycles = 0, i;
  always #2 clk = ~clk;
  // Short timeout counts keep the run brief
  ctrl_channel_gpio_cfg_regs #(.TIMEOUT_US_0(1), .TIMEOUT_US_1(2), .TIMEOUT_US_2(3)) dut_u (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .fwdChannelUp(fwdUp), .bridgeAckRequest(ackReq),
    .bridgeLocalAck(lAck), .bridgeSlaveSetupHoldSel(shSel), .bridgeMasterRateSel(rateSel),
    .bridgeSlaveTimeoutSel(toSel), .bridgeRemoteWaitStart(rws), .bridgeRemoteDone(rdn),
    .bridgeRemoteTimeout(rTo), .triggerInputLevel(trig), .triggerForwardLevel(fLvl),
    .triggerForwardValid(fVld), .pin0In(p0In), .pin1In(p1In), .pin0Out(p0O),
    .pin0Oe_n(p0Oe_n), .pin1Out(p1O), .pin1Oe_n(p1Oe_n), .detectedErrorPulse(errP),
    .errorFlag(errF), .irq(irq));
  serializer_gpo_model far_u (.clk(clk), .rst_n(rst_n), .fwdLevel(fLvl), .fwdValid(fVld),
    .gpoLevel(gpo));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checksDone = checksDone + 1;
      if (seen !== exp)
      begin
        nErrors = nErrors + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Handshakes are judged at the falling edge, where nothing moves
  task axiWrite(input [9:0] a, input [31:0] v);
    reg aw, w, b;
    begin
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      b = 1'h0;
      while (!b)
      begin
        @(negedge clk);
        aw = awv & awr;
        w = wv & wr;
        b = bv & br;
        r = bresp;
        @(posedge clk);
        if (aw) awv <= 1'h0;
        if (w) wv <= 1'h0;
        if (b) br <= 1'h0;
      end
    end
  endtask
  task axiRead(input [9:0] a);
    reg ar, rd;
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      rd = 1'h0;
      while (!rd)
      begin
        @(negedge clk);
        ar = arv & arr;
        rd = rv & rr;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (ar) arv <= 1'h0;
        if (rd) rr <= 1'h0;
      end
    end
  endtask
  task waitCy(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    begin
      axiRead(`ADDR_BRIDGE_CFG);
      check("cfg", d, 32'h36);
      check("sel", {shSel, rateSel, toSel}, 32'h36);
      axiRead(`ADDR_GPIO_FWD);
      check("gpio", d, 32'h6a);
      axiRead(`ADDR_DET_THR);
      check("thr", d, 32'h0);
      axiRead(`ADDR_DET_COUNT);
      check("count", d, 32'h0);
    end
  endtask
  task t_bridge;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        c = i;
        axiWrite(`ADDR_BRIDGE_CFG, {24'h0, 1'h0, c[1:0], c, c[1:0]});
        axiRead(`ADDR_BRIDGE_CFG);
        waitCy(2);
        check("cfgrd", d, {24'h0, 1'h0, c[1:0], c, c[1:0]});
        check("selout", {shSel, rateSel, toSel}, {c[1:0], c, c[1:0]});
      end
      axiWrite(`ADDR_BRIDGE_CFG, 32'hb6);
      fwdUp <= 1'h0;
      ackReq <= 1'h1;
      waitCy(3);
      check("ackon", lAck, 1'h1);
      fwdUp <= 1'h1;
      waitCy(3);
      check("ackup", lAck, 1'h0);
      fwdUp <= 1'h0;
      axiWrite(`ADDR_BRIDGE_CFG, 32'h36);
      waitCy(3);
      check("ackoff", lAck, 1'h0);
      fwdUp <= 1'h1;
    end
  endtask
  task t_forward;
    begin
      trig <= 1'h1;
      p0In <= 1'h1;
      waitCy(10);
      check("gpo", gpo, 1'h1);
      axiRead(`ADDR_GPIO_FWD);
      check("gpiord", d, 32'h7b);
      axiWrite(`ADDR_GPIO_FWD, 32'h48);
      trig <= 1'h0;
      waitCy(10);
      check("fwdoff", {fVld, gpo, p0Oe_n, p1Oe_n, p0O, p1O}, 6'h14);
      axiWrite(`ADDR_GPIO_FWD, 32'h6a);
      waitCy(10);
      check("gpo0", gpo, 1'h0);
    end
  endtask
  task pulse(input integer n);
    repeat (n)
    begin
      @(posedge clk);
      errP <= 1'h1;
      @(posedge clk);
      errP <= 1'h0;
    end
  endtask
  task t_errors;
    begin
      axiWrite(`ADDR_DET_THR, 32'h3);
      axiRead(`ADDR_DET_THR);
      check("thrrd", d, 32'h3);
      pulse(3);
      waitCy(5);
      axiRead(`ADDR_DET_COUNT);
      check("cnt3", d, 32'h3);
      check("flag0", {errF, irq}, 2'h0);
      pulse(1);
      waitCy(5);
      check("flag1", {errF, irq}, 2'h2);
      axiWrite(`ADDR_DET_COUNT, 32'h0);
      check("bresp", r, 32'h0);
      axiRead(`ADDR_DET_COUNT);
      check("cntro", d, 32'h4);
      axiWrite(`ADDR_IRQ_MASK, 32'h1);
      waitCy(2);
      check("irq1", irq, 1'h1);
      axiWrite(`ADDR_IRQ_STATUS, 32'h1);
      waitCy(2);
      check("irq0", irq, 1'h0);
      axiWrite(`ADDR_ERR_SEL, 32'h1);
      waitCy(3);
      check("selflag", errF, 1'h0);
      axiRead(10'h3fc);
      check("unmap", {r, d}, {2'h2, 32'h0});
    end
  endtask
  task t_timeout;
    integer n;
    begin
      axiWrite(`ADDR_IRQ_STATUS, 32'h3);
      rws <= 1'h1;
      @(posedge clk);
      rws <= 1'h0;
      n = 0;
      while (rTo !== 1'h1 && n < 1000)
      begin
        @(posedge clk);
        n = n + 1;
      end
      // Three microseconds as set at the instance, plus the output flop
      check("tocyc", n, 3 * `CLK_MHZ + 1);
      axiRead(`ADDR_IRQ_STATUS);
      check("tostat", d, 32'h2);
      for (i = 0; i < 2; i = i + 1)
      begin
        axiWrite(`ADDR_IRQ_STATUS, 32'h2);
        if (i == 1)
          axiWrite(`ADDR_BRIDGE_CFG, 32'h37);
        rws <= 1'h1;
        @(posedge clk);
        rws <= 1'h0;
        rdn <= (i == 0);
        @(posedge clk);
        rdn <= 1'h0;
        waitCy(800);
        axiRead(`ADDR_IRQ_STATUS);
        check("tostop", d, 32'h0);
      end
    end
  endtask
  task print_verdict;
    begin
      if (nErrors == 0 && checksDone > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      nErrors = nErrors + 1;
      print_verdict;
    end
  end
  initial
  begin
    waitCy(8);
    rst_n <= 1'h1;
    t_defaults;
    t_bridge;
    t_forward;
    t_errors;
    t_timeout;
    print_verdict;
  end
endmodule
